/* hw/spcfg_params.svh */
// constants for the serial port configuration register block
`ifndef SPCFG_PARAMS_SVH
`define SPCFG_PARAMS_SVH
`define SPCFG_ADDR_CFG 8'h02
`define SPCFG_ADDR_DATA 8'h04
`define SPCFG_ADDR_STATUS 8'h00
`define SPCFG_CFG_RESET 16'h0000
`define SPCFG_CFG_WMASK 16'h19EF
`define SPCFG_BIT_ALT_GATE 12
`define SPCFG_BIT_DRIVE 11
`define SPCFG_BIT_DOUT_RST 8
`define SPCFG_BIT_CONT_READ 7
`define SPCFG_BIT_APPEND_STAT 6
`define SPCFG_BIT_INTEG 5
`define SPCFG_CKS_MSB 3
`define SPCFG_CKS_LSB 2
`define SPCFG_BIT_SHORT 0
`define SPCFG_CKS_OFF 2'h0
`define SPCFG_CKS_XOR_RD 2'h1
`define SPCFG_CKS_CRC_RW 2'h2
`define SPCFG_STAT_REGERR_BIT 6
`endif

/* hw/spcfg_pkg.sv */
// types shared by the serial port configuration block
package spcfg_pkg;
    typedef enum logic [1:0] {
        SPCFG_CKS_NONE = 2'h0,
        SPCFG_CKS_XOR = 2'h1,
        SPCFG_CKS_CRC = 2'h2,
        SPCFG_CKS_RSVD = 2'h3
    } spcfg_cks_e;
    // decoded configuration for the rest of the converter
    typedef struct packed {
        logic alternate_gate_behaviour;
        logic output_drive_boost;
        logic dout_reset_en;
        logic continuous_result_read;
        logic append_status;
        logic integrity_en;
        spcfg_cks_e checksum_mode;
        logic short_result_width;
    } spcfg_ctrl_s;
    // one register access from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } spcfg_req_s;
    typedef enum logic [2:0] {
        SPCFG_ST_IDLE = 3'b001,
        SPCFG_ST_ARMED = 3'b010,
        SPCFG_ST_FAULT = 3'b100
    } spcfg_chk_e;
endpackage

/* hw/spcfg_sync.sv */
// toggle-based event crossing into the device clock domain
`timescale 1ns/100ps
`default_nettype none
module spcfg_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic toggle_in,
    output logic pulse_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    // first stage only feeds second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= toggle_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign pulse_out = s2_reg ^ s3_reg;
endmodule // spcfg_sync
`default_nettype wire

/* hw/spcfg_top.sv */
// serial port configuration register with integrity checker
// Function
// - configuration register lives at address 02h and resets to zero.
// - bit 12 selects alternate sync gating while channels are cycled.
// - bit 11 selects stronger drive on the data-out/ready pin.
// - bit 8 enables the data-out reset option.
// - bit 7 enables continuous read of the conversion result.
// - bit 6 appends status word after each data register read.
// - appended status belongs to the same conversion as the data.
// - bit 5 turns on the register integrity checker.
// - checked register change while enabled sets the register-error flag.
// - writing zero to the integrity enable clears the error flag.
// - configuration, data and status registers are not checked.
// - bits 3:2 select checksum protection; 00 disables it.
// - checksum adds one byte to each serial transfer.
// - code 01 uses XOR on reads, CRC on writes.
// - code 10 uses CRC on reads and writes.
// - bit 0 shortens results to 16 bits from the next new result.
`timescale 1ns/100ps
`default_nettype none
`include "spcfg_params.svh"
module spcfg_top
    import spcfg_pkg::*;
#(
    parameter int RES_W = 24,
    parameter int STAT_W = 8
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic LINK_CLK,
    input wire logic LINK_RSTN,
    input wire logic LINK_WR,
    input wire logic LINK_RD,
    input wire logic [7:0] LINK_ADDR,
    input wire logic [15:0] LINK_WDATA,
    input wire logic LINK_DONE,
    input wire logic [RES_W-1:0] CONV_DATA,
    input wire logic [STAT_W-1:0] CONV_STATUS,
    input wire logic CONV_VALID,
    output logic [15:0] CFG_RDATA,
    output logic [RES_W+STAT_W-1:0] RESULT_WORD,
    output logic [5:0] RESULT_BITS,
    output logic [2:0] XFER_EXTRA_BYTES,
    output logic RD_USE_XOR,
    output logic WR_USE_CRC,
    output logic RD_USE_CRC,
    output spcfg_ctrl_s CTRL,
    output logic REG_ERROR
);
    initial begin
        if (RES_W != 24 || STAT_W != 8) begin
            $error("spcfg_top: result width must be 24, status width 8");
        end
    end

    // link domain: capture one completed access, toggle to announce it
    spcfg_req_s link_req_reg;
    logic link_tog_reg;
    logic link_pend_reg;
    always_ff @(posedge LINK_CLK or negedge LINK_RSTN) begin
        if (!LINK_RSTN) begin
            link_req_reg <= '0;
            link_pend_reg <= 1'b0;
            link_tog_reg <= 1'b0;
        end else if (LINK_DONE && link_pend_reg) begin
            link_tog_reg <= ~link_tog_reg;
            link_pend_reg <= 1'b0;
        end else if (LINK_WR || LINK_RD) begin
            link_req_reg <= '{wr: LINK_WR, rd: LINK_RD,
                              addr: LINK_ADDR, wdata: LINK_WDATA};
            link_pend_reg <= 1'b1;
        end
    end
    // request word stays stable from capture until long after the toggle

    logic evt_pulse;
    spcfg_sync u_sync (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .toggle_in(link_tog_reg),
        .pulse_out(evt_pulse)
    );

    // quasi-static request word, sampled only on the synchronised event
    spcfg_req_s req;
    assign req = link_req_reg;
    logic cfg_wr;
    logic chk_wr;
    assign cfg_wr = evt_pulse && req.wr && req.addr == `SPCFG_ADDR_CFG;
    // any other writable register is a checked user register
    assign chk_wr = evt_pulse && req.wr && req.addr != `SPCFG_ADDR_CFG
        && req.addr != `SPCFG_ADDR_DATA
        && req.addr != `SPCFG_ADDR_STATUS;

    // configuration register, reserved bits forced to zero
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_wr) begin
            cfg_next = req.wdata & `SPCFG_CFG_WMASK;
        end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_reg <= `SPCFG_CFG_RESET;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // integrity checker; a clear on the enable beats a simultaneous event
    // because the only clear source is the configuration write itself
    spcfg_chk_e chk_st_reg;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            chk_st_reg <= SPCFG_ST_IDLE;
        end else begin
            case (chk_st_reg)
                SPCFG_ST_IDLE: begin
                    if (cfg_next[`SPCFG_BIT_INTEG]) begin
                        chk_st_reg <= SPCFG_ST_ARMED;
                    end
                end
                SPCFG_ST_ARMED: begin
                    if (!cfg_next[`SPCFG_BIT_INTEG]) begin
                        chk_st_reg <= SPCFG_ST_IDLE;
                    end else if (chk_wr) begin
                        chk_st_reg <= SPCFG_ST_FAULT;
                    end
                end
                SPCFG_ST_FAULT: begin
                    if (!cfg_next[`SPCFG_BIT_INTEG]) begin
                        chk_st_reg <= SPCFG_ST_IDLE;
                    end
                end
                default: chk_st_reg <= SPCFG_ST_IDLE;
            endcase
        end
    end

    // decode of checksum mode, shared by several outputs
    function automatic spcfg_cks_e cks_of(input logic [15:0] c);
        cks_of = spcfg_cks_e'(c[`SPCFG_CKS_MSB:`SPCFG_CKS_LSB]);
    endfunction

    // registered control outputs follow the committed configuration
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            CTRL <= '0;
            CFG_RDATA <= `SPCFG_CFG_RESET;
            XFER_EXTRA_BYTES <= 3'h0;
            RD_USE_XOR <= 1'b0;
            RD_USE_CRC <= 1'b0;
            WR_USE_CRC <= 1'b0;
            REG_ERROR <= 1'b0;
        end else begin
            CTRL.alternate_gate_behaviour <=
                cfg_next[`SPCFG_BIT_ALT_GATE];
            CTRL.output_drive_boost <= cfg_next[`SPCFG_BIT_DRIVE];
            CTRL.dout_reset_en <= cfg_next[`SPCFG_BIT_DOUT_RST];
            CTRL.continuous_result_read <=
                cfg_next[`SPCFG_BIT_CONT_READ];
            CTRL.append_status <= cfg_next[`SPCFG_BIT_APPEND_STAT];
            CTRL.integrity_en <= cfg_next[`SPCFG_BIT_INTEG];
            CTRL.checksum_mode <= cks_of(cfg_next);
            CTRL.short_result_width <= cfg_next[`SPCFG_BIT_SHORT];
            CFG_RDATA <= cfg_next;
            XFER_EXTRA_BYTES <= (cks_of(cfg_next) == SPCFG_CKS_NONE)
                ? 3'h0 : 3'h1;
            RD_USE_XOR <= cks_of(cfg_next) == SPCFG_CKS_XOR;
            WR_USE_CRC <= cks_of(cfg_next) == SPCFG_CKS_XOR
                || cks_of(cfg_next) == SPCFG_CKS_CRC;
            RD_USE_CRC <= cks_of(cfg_next) == SPCFG_CKS_CRC;
            REG_ERROR <= (chk_st_reg == SPCFG_ST_FAULT
                || (chk_st_reg == SPCFG_ST_ARMED && chk_wr))
                && cfg_next[`SPCFG_BIT_INTEG];
        end
    end

    // result word: data and its own status latched together;
    // word length only changes with a new conversion
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RESULT_WORD <= '0;
            RESULT_BITS <= 6'd24;
        end else if (CONV_VALID) begin
            if (cfg_reg[`SPCFG_BIT_SHORT]) begin
                RESULT_WORD <= {8'h00, CONV_DATA[RES_W-1 -: 16], CONV_STATUS};
                RESULT_BITS <= cfg_reg[`SPCFG_BIT_APPEND_STAT]
                    ? 6'd24 : 6'd16;
            end else begin
                RESULT_WORD <= {CONV_DATA, CONV_STATUS};
                RESULT_BITS <= cfg_reg[`SPCFG_BIT_APPEND_STAT]
                    ? 6'd32 : 6'd24;
            end
        end
    end
endmodule // spcfg_top
`default_nettype wire

/* verification/spcfg_monitor.sv */
// checker of configuration decode and integrity flag
`timescale 1ns/100ps
`default_nettype none
module spcfg_monitor
    import spcfg_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [15:0] CFG_RDATA,
    input wire logic [2:0] XFER_EXTRA_BYTES,
    input wire logic RD_USE_XOR,
    input wire logic WR_USE_CRC,
    input wire logic RD_USE_CRC,
    input wire spcfg_ctrl_s CTRL,
    input wire logic REG_ERROR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // reserved bits stay zero; gate, drive, dout and cont fields must always follow the stored word
    property p_rsvd; (CFG_RDATA & ~16'h19EF) == 16'h0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_gate;
        CTRL.alternate_gate_behaviour == CFG_RDATA[12];
    endproperty
    a_gate: assert property (p_gate) else $error("gate bit");
    property p_drive; CTRL.output_drive_boost == CFG_RDATA[11]; endproperty
    a_drive: assert property (p_drive) else $error("drive bit");
    property p_dout; CTRL.dout_reset_en == CFG_RDATA[8]; endproperty
    a_dout: assert property (p_dout) else $error("dout bit");
    property p_cont; CTRL.continuous_result_read == CFG_RDATA[7]; endproperty
    a_cont: assert property (p_cont) else $error("cont bit");
    // one checksum byte whenever the field is nonzero
    property p_extra;
        XFER_EXTRA_BYTES == {2'h0, CFG_RDATA[3:2] != 2'h0};
    endproperty
    a_extra: assert property (p_extra) else $error("extra byte");
    property p_xor;
        (RD_USE_XOR == (CFG_RDATA[3:2] == 2'h1))
        && (WR_USE_CRC == (CFG_RDATA[3:2] == 2'h1
            || CFG_RDATA[3:2] == 2'h2));
    endproperty
    a_xor: assert property (p_xor) else $error("xor select");
    property p_crc; RD_USE_CRC == (CFG_RDATA[3:2] == 2'h2); endproperty
    a_crc: assert property (p_crc) else $error("crc select");
    // the flag only rises while checking was already on
    property p_set; $rose(REG_ERROR) |-> $past(CFG_RDATA[5]); endproperty
    a_set: assert property (p_set) else $error("flag without check");
    property p_clr; $fell(CFG_RDATA[5]) |-> !REG_ERROR; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    c_err: cover property ($rose(REG_ERROR));
    c_clr: cover property ($fell(REG_ERROR));
    c_extra: cover property (XFER_EXTRA_BYTES == 3'h1);
endmodule // spcfg_monitor
bind spcfg_top spcfg_monitor i_spcfg_monitor (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .CFG_RDATA(CFG_RDATA), .XFER_EXTRA_BYTES(XFER_EXTRA_BYTES),
    .RD_USE_XOR(RD_USE_XOR), .WR_USE_CRC(WR_USE_CRC), .RD_USE_CRC(RD_USE_CRC),
    .CTRL(CTRL), .REG_ERROR(REG_ERROR));
`default_nettype wire

/* verification/spcfg_host.sv */
// host-side model of the serial engine access strobes
`timescale 1ns/100ps
`default_nettype none
module spcfg_host (
    input wire logic LINK_CLK,
    output logic LINK_WR,
    output logic LINK_RD,
    output logic [7:0] LINK_ADDR,
    output logic [15:0] LINK_WDATA,
    output logic LINK_DONE
);
    initial begin
        LINK_WR = 1'b0;
        LINK_RD = 1'b0;
        LINK_ADDR = 8'h00;
        LINK_WDATA = 16'h0000;
        LINK_DONE = 1'b0;
    end
    // one access, held stable until the commit edge has passed
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [15:0] d);
        @(negedge LINK_CLK);
        LINK_WR = w;
        LINK_RD = !w;
        LINK_ADDR = a;
        LINK_WDATA = d;
        @(negedge LINK_CLK);
        LINK_DONE = 1'b1;
        @(negedge LINK_CLK);
        LINK_DONE = 1'b0;
        LINK_WR = 1'b0;
        LINK_RD = 1'b0;
        LINK_ADDR = ~a; // released bus must not look like the old access
        LINK_WDATA = ~d;
    endtask
endmodule // spcfg_host
`default_nettype wire

/* verification/test_spcfg_top.sv */
// testbench for the serial port configuration register block
`timescale 1ns/100ps
`default_nettype none
module test_spcfg_top
    import spcfg_pkg::*;
;
    logic ref_clk, rstn, link_clk, link_rstn, wr, rd, done, conv_valid;
    logic rd_xor, wr_crc, rd_crc, reg_error;
    logic [7:0] addr, conv_status;
    logic [15:0] wdata, cfg_rdata, w;
    logic [23:0] conv_data;
    logic [31:0] result_word;
    logic [5:0] result_bits;
    logic [2:0] extra;
    spcfg_ctrl_s ctrl;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] vals [10] = '{16'h1000, 16'h0800, 16'h0100, 16'h0080,
        16'h0040, 16'h0020, 16'h0004, 16'h0008, 16'h0001, 16'hFFF3};
    spcfg_top i_spcfg_top (.REF_CLK(ref_clk), .RSTN(rstn),
        .LINK_CLK(link_clk), .LINK_RSTN(link_rstn), .LINK_WR(wr),
        .LINK_RD(rd), .LINK_ADDR(addr), .LINK_WDATA(wdata), .LINK_DONE(done),
        .CONV_DATA(conv_data), .CONV_STATUS(conv_status),
        .CONV_VALID(conv_valid), .CFG_RDATA(cfg_rdata),
        .RESULT_WORD(result_word), .RESULT_BITS(result_bits),
        .XFER_EXTRA_BYTES(extra), .RD_USE_XOR(rd_xor), .WR_USE_CRC(wr_crc),
        .RD_USE_CRC(rd_crc), .CTRL(ctrl), .REG_ERROR(reg_error));
    spcfg_host i_spcfg_host (.LINK_CLK(link_clk), .LINK_WR(wr), .LINK_RD(rd),
        .LINK_ADDR(addr), .LINK_WDATA(wdata), .LINK_DONE(done));
    // clocks with unrelated phases
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // access, then allow the crossing and output update to settle
    task automatic acc(input logic w1, input logic [7:0] a,
        input logic [15:0] d);
        i_spcfg_host.xfer(w1, a, d);
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic conv(input logic [23:0] d, input logic [7:0] s);
        @(negedge ref_clk);
        conv_data = d;
        conv_status = s;
        conv_valid = 1'b1;
        @(negedge ref_clk);
        conv_valid = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard: the sequence needs well under 3000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        rstn = 1'b0;
        link_rstn = 1'b0;
        conv_data = 24'h000000;
        conv_status = 8'h00;
        conv_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        link_rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("cfg", 32'h0, {16'h0, cfg_rdata});
        chk("bits", 32'd24, {26'h0, result_bits});
        // one conversion already runs before continuous read is set
        conv(24'h654321, 8'h11);
        chk("first", {24'h654321, 8'h11}, result_word);
        foreach (vals[i]) begin
            w = vals[i] & 16'h19EF;
            acc(1'b1, 8'h02, vals[i]);
            chk("cfg", {16'h0, w}, {16'h0, cfg_rdata});
            chk("ctrl", {23'h0, w[12:11], w[8:5], w[3:2], w[0]},
                {23'h0, ctrl});
            chk("cks", {26'h0, w[3:2] == 2'h1, |w[3:2], w[3:2] == 2'h2,
                2'h0, |w[3:2]},
                {26'h0, rd_xor, wr_crc, rd_crc, extra});
        end
        acc(1'b1, 8'h02, 16'h0041);
        conv(24'hABCDEF, 8'h35);
        chk("short", {8'h00, 16'hABCD, 8'h35}, result_word);
        chk("bits", 32'd24, {26'h0, result_bits});
        acc(1'b1, 8'h02, 16'h0040);
        conv(24'h123456, 8'h5A);
        chk("full", {24'h123456, 8'h5A}, result_word);
        chk("bits", 32'd32, {26'h0, result_bits});
        acc(1'b1, 8'h02, 16'h0020);
        acc(1'b1, 8'h04, 16'h1234);
        chk("err", 32'h0, {31'h0, reg_error});
        acc(1'b0, 8'h10, 16'h0000);
        chk("err", 32'h0, {31'h0, reg_error});
        acc(1'b1, 8'h10, 16'h0055);
        chk("err", 32'h1, {31'h0, reg_error});
        acc(1'b1, 8'h02, 16'h0000);
        chk("err", 32'h0, {31'h0, reg_error});
        acc(1'b1, 8'h10, 16'h00AA);
        chk("err", 32'h0, {31'h0, reg_error});
        conclude();
    end
endmodule // test_spcfg_top
`default_nettype wire
